// [rtl/cleqe_cfg.svh]
// Offsets, field positions, reset values and sizes for the logic equation engine.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz clock.
`ifndef CLEQE_CFG_SVH
`define CLEQE_CFG_SVH
// ==========================================================================
// Sizes
`define CLEQE_NUM_EQ      8
`define CLEQE_NUM_EXT     32
`define CLEQE_SEL_W       6
`define CLEQE_EQ_W        3
`define CLEQE_DLY_W       16
// ==========================================================================
// Register map (byte addresses), per-equation block of four words.
`define CLEQE_OFS_CTRL    12'h000
`define CLEQE_OFS_STATUS  12'h004
`define CLEQE_OFS_OUTS    12'h008
`define CLEQE_OFS_EQ_BASE 12'h100
`define CLEQE_EQ_STRIDE   12'h010
`define CLEQE_EQ_SEL      2'h0
`define CLEQE_EQ_CFG      2'h1
`define CLEQE_EQ_DLY      2'h2
`define CLEQE_EQ_STAT     2'h3
// ==========================================================================
// Field positions in the configuration word.
`define CLEQE_CFG_INV_LO  0
`define CLEQE_CFG_RINV    4
`define CLEQE_CFG_GATE_LO 8
`define CLEQE_CFG_RSEL_LO 16
// ==========================================================================
// Reset values and responses.
`define CLEQE_CTRL_RST    1'h0
`define CLEQE_RESP_OKAY   2'h0
`define CLEQE_RESP_SLVERR 2'h2
`endif

// [rtl/cleqe_engine.sv]
// Cyclic logic equation engine with an AXI4-Lite register slave.
// Assumes the assignable signals arrive asynchronously and are resynchronised here.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cleqe_cfg.svh"

// Notes on behaviour
// - Each equation picks up to four inputs from the assignable signal list.
// - Each of the four inputs may be negated before the gate.
// - Gate result passes one delay timer with separate rise and fall delay limits.
// - Each equation gives an unlatched and a latched result.
// - Latched result is also given in complemented form.
// - Latch reset is chosen from the list and may be negated.
// - Reset dominates set when both are active.
// - Equations evaluate in ascending order, cycle repeating while the control enable bit is set.
// - Equation outputs are selectable as inputs of other equations.
// - Lower feeding higher sees the value from the same cycle.
// - Higher feeding lower sees the value from the previous cycle.
// - Outputs drive relays and blocking of protective functions.
// - Input and output states of every equation are readable.
module cleqe_engine (
  input  wire  logic                       CLOCK,         // 100 MHz clock.
  input  wire  logic                       RESETN,        // Asynchronous reset, active low.
  input  wire  logic [`CLEQE_NUM_EXT-1:0]  SIGNALS_IN,    // Assignable device signals.
  output var   logic [`CLEQE_NUM_EQ-1:0]   EQ_OUT,        // Unlatched results.
  output var   logic [`CLEQE_NUM_EQ-1:0]   EQ_LATCHED,    // Latched results.
  output var   logic [`CLEQE_NUM_EQ-1:0]   EQ_LATCHED_N,  // Complemented latched results.
  output var   logic                       CYCLE_DONE,    // Pulse at the end of each cycle.
  input  wire  logic [11:0]                AWADDR,        // Write address.
  input  wire  logic                       AWVALID,       // Write address valid.
  output var   logic                       AWREADY,       // Write address ready.
  input  wire  logic [31:0]                WDATA,         // Write data.
  input  wire  logic [3:0]                 WSTRB,         // Write strobes.
  input  wire  logic                       WVALID,        // Write data valid.
  output var   logic                       WREADY,        // Write data ready.
  output var   logic [1:0]                 BRESP,         // Write response.
  output var   logic                       BVALID,        // Write response valid.
  input  wire  logic                       BREADY,        // Write response ready.
  input  wire  logic [11:0]                ARADDR,        // Read address.
  input  wire  logic                       ARVALID,       // Read address valid.
  output var   logic                       ARREADY,       // Read address ready.
  output var   logic [31:0]                RDATA,         // Read data.
  output var   logic [1:0]                 RRESP,         // Read response.
  output var   logic                       RVALID,        // Read data valid.
  input  wire  logic                       RREADY         // Read data ready.
);

  localparam int NEQ = `CLEQE_NUM_EQ;

  // ==========================================================================
  // Signal resynchronisation.
  // Only sync2 is read by the equations; sync1 feeds nothing else.
  logic [`CLEQE_NUM_EXT-1:0] sync1_r;
  logic [`CLEQE_NUM_EXT-1:0] sync2_r;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= SIGNALS_IN;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================================
  // Storage.
  cleqe_pkg::cleqe_eqcfg_t [NEQ-1:0] cfg_r, cfg_nxt;
  cleqe_pkg::cleqe_eqst_t  [NEQ-1:0] st_r, st_nxt;
  logic [`CLEQE_NUM_EQ-1:0]           out_r, out_nxt;
  logic [`CLEQE_EQ_W-1:0]             idx_r, idx_nxt;
  cleqe_pkg::cleqe_seq_t              seq_r, seq_nxt;
  logic                               en_r, en_nxt;
  logic                               done_r, done_nxt;
  logic [31:0]                        cycles_r, cycles_nxt;

  // Selector codes below NUM_EXT pick a device signal, the next eight an equation, higher codes read 0.
  // The equation bit comes from out_r, which already holds this cycle's result
  // for lower equations and last cycle's for higher ones.
  function automatic logic pick(input logic [`CLEQE_SEL_W-1:0] sel,
                                input logic [`CLEQE_NUM_EXT-1:0] ext,
                                input logic [`CLEQE_NUM_EQ-1:0] eqs);
    logic [`CLEQE_SEL_W-1:0] k;
    k = sel - `CLEQE_SEL_W'(`CLEQE_NUM_EXT);
    if (sel < `CLEQE_SEL_W'(`CLEQE_NUM_EXT)) begin
      pick = ext[sel[4:0]];
    end else if (k < `CLEQE_SEL_W'(`CLEQE_NUM_EQ)) begin
      pick = eqs[k[`CLEQE_EQ_W-1:0]];
    end else begin
      pick = 1'b0;
    end
  endfunction : pick

  // ==========================================================================
  // Evaluation sequencer: one equation per clock, ascending, repeating.
  always_comb begin
    cleqe_pkg::cleqe_eqcfg_t c;
    cleqe_pkg::cleqe_eqst_t  s;
    logic [3:0]              ci;
    logic                    g;
    logic                    rs;
    c          = cfg_r[idx_r];
    s          = st_r[idx_r];
    ci         = '0;
    g          = 1'b0;
    rs         = 1'b0;
    st_nxt     = st_r;
    out_nxt    = out_r;
    idx_nxt    = idx_r;
    seq_nxt    = seq_r;
    done_nxt   = 1'b0;
    cycles_nxt = cycles_r;
    case (seq_r)
      cleqe_pkg::SEQ_IDLE: begin
        idx_nxt = '0;
        if (en_r) begin
          seq_nxt = cleqe_pkg::SEQ_RUN;
        end
      end
      cleqe_pkg::SEQ_RUN: begin
        for (int i = 0; i < 4; i++) begin
          ci[i] = pick(c.equation_input_slot[i], sync2_r, out_r) ^ c.inv[i];
        end
        case (c.gate)
          cleqe_pkg::GATE_AND:  g = &ci;
          cleqe_pkg::GATE_OR:   g = |ci;
          cleqe_pkg::GATE_NAND: g = ~&ci;
          default:              g = ~|ci;
        endcase
        // Timer counts cycles the gate has differed from the output.
        s.ins    = ci;
        s.gate_q = g;
        if (g == s.unl) begin
          s.cnt = '0;
        end else if (g && s.cnt >= c.equation_rise_delay) begin
          s.unl = 1'b1;
          s.cnt = '0;
        end else if (!g && s.cnt >= c.equation_fall_delay) begin
          s.unl = 1'b0;
          s.cnt = '0;
        end else begin
          s.cnt = s.cnt + 1'b1;
        end
        rs    = pick(c.rst_sel, sync2_r, out_r) ^ c.rst_inv;
        s.rst = rs;
        if (rs) begin
          s.lat = 1'b0;
        end else if (s.unl) begin
          s.lat = 1'b1;
        end
        st_nxt[idx_r]  = s;
        out_nxt[idx_r] = s.unl;
        if (idx_r == `CLEQE_EQ_W'(NEQ - 1)) begin
          idx_nxt    = '0;
          done_nxt   = 1'b1;
          cycles_nxt = cycles_r + 32'h0000_0001;
          if (!en_r) begin
            seq_nxt = cleqe_pkg::SEQ_IDLE;
          end
        end else begin
          idx_nxt = idx_r + 1'b1;
        end
      end
      default: seq_nxt = cleqe_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      st_r     <= '0;
      out_r    <= '0;
      idx_r    <= '0;
      seq_r    <= cleqe_pkg::SEQ_IDLE;
      done_r   <= 1'b0;
      cycles_r <= '0;
    end else begin
      st_r     <= st_nxt;
      out_r    <= out_nxt;
      idx_r    <= idx_nxt;
      seq_r    <= seq_nxt;
      done_r   <= done_nxt;
      cycles_r <= cycles_nxt;
    end
  end

  // ==========================================================================
  // Result outputs, all registered.
  logic [`CLEQE_NUM_EQ-1:0] lat_r, lat_nxt;

  always_comb begin
    for (int i = 0; i < NEQ; i++) begin
      lat_nxt[i] = st_nxt[i].lat;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      lat_r        <= '0;
      EQ_LATCHED_N <= '1;
    end else begin
      lat_r        <= lat_nxt;
      EQ_LATCHED_N <= ~lat_nxt;
    end
  end

  assign EQ_OUT     = out_r;
  assign EQ_LATCHED = lat_r;
  assign CYCLE_DONE = done_r;

  // ==========================================================================
  // AXI4-Lite slave. Address and data are taken in either order; the
  // response follows one cycle after both are held.
  logic        aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
  logic [11:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic        bv_nxt, arr_nxt, rv_nxt, awr_nxt, wr_nxt;
  logic [1:0]  br_nxt, rr_nxt;
  logic [31:0] rd_nxt;

  // Merges strobed bytes of a write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = st[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
    merge = old;
  endfunction : merge

  always_comb begin
    logic [11:0]            a;
    logic [`CLEQE_EQ_W-1:0] e;
    logic [31:0]            w;
    a        = awa_r - `CLEQE_OFS_EQ_BASE;
    e        = a[4 +: `CLEQE_EQ_W];
    w        = '0;
    aw_h_nxt = aw_h_r | (AWVALID & AWREADY);
    w_h_nxt  = w_h_r | (WVALID & WREADY);
    awa_nxt  = (AWVALID & AWREADY) ? AWADDR : awa_r;
    wd_nxt   = (WVALID & WREADY) ? WDATA : wd_r;
    ws_nxt   = (WVALID & WREADY) ? WSTRB : ws_r;
    awr_nxt  = !aw_h_nxt && !BVALID;
    wr_nxt   = !w_h_nxt && !BVALID;
    bv_nxt   = BVALID & ~BREADY;
    br_nxt   = BRESP;
    cfg_nxt  = cfg_r;
    en_nxt   = en_r;
    if (aw_h_r && w_h_r && !BVALID) begin
      bv_nxt   = 1'b1;
      br_nxt   = `CLEQE_RESP_OKAY;
      aw_h_nxt = 1'b0;
      w_h_nxt  = 1'b0;
      awr_nxt  = 1'b0;
      wr_nxt   = 1'b0;
      if (awa_r == `CLEQE_OFS_CTRL) begin
        en_nxt = ws_r[0] ? wd_r[0] : en_r;
      end else if (awa_r >= `CLEQE_OFS_EQ_BASE && a < 12'(NEQ * 16)
                   && a[3:2] == `CLEQE_EQ_SEL) begin
        w = merge({2'h0, cfg_r[e].equation_input_slot[3], 2'h0,
                   cfg_r[e].equation_input_slot[2], 2'h0,
                   cfg_r[e].equation_input_slot[1], 2'h0,
                   cfg_r[e].equation_input_slot[0]}, wd_r, ws_r);
        for (int i = 0; i < 4; i++) begin
          cfg_nxt[e].equation_input_slot[i] = w[8*i +: `CLEQE_SEL_W];
        end
      end else if (awa_r >= `CLEQE_OFS_EQ_BASE && a < 12'(NEQ * 16)
                   && a[3:2] == `CLEQE_EQ_CFG) begin
        w = merge(32'h0, wd_r, ws_r);
        cfg_nxt[e].inv     = w[`CLEQE_CFG_INV_LO +: 4];
        cfg_nxt[e].rst_inv = w[`CLEQE_CFG_RINV];
        cfg_nxt[e].gate    = cleqe_pkg::cleqe_gate_t'(w[`CLEQE_CFG_GATE_LO +: 2]);
        cfg_nxt[e].rst_sel = w[`CLEQE_CFG_RSEL_LO +: `CLEQE_SEL_W];
      end else if (awa_r >= `CLEQE_OFS_EQ_BASE && a < 12'(NEQ * 16)
                   && a[3:2] == `CLEQE_EQ_DLY) begin
        w = merge({cfg_r[e].equation_fall_delay, cfg_r[e].equation_rise_delay},
                  wd_r, ws_r);
        cfg_nxt[e].equation_rise_delay = w[15:0];
        cfg_nxt[e].equation_fall_delay = w[31:16];
      end else begin
        br_nxt = `CLEQE_RESP_SLVERR;
      end
    end
  end

  // Read side: one read at a time, answered the cycle after it is taken.
  always_comb begin
    logic [11:0]            a;
    logic [`CLEQE_EQ_W-1:0] e;
    a       = ARADDR - `CLEQE_OFS_EQ_BASE;
    e       = a[4 +: `CLEQE_EQ_W];
    arr_nxt = !RVALID && !(ARVALID && ARREADY);
    rv_nxt  = RVALID & ~RREADY;
    rd_nxt  = RDATA;
    rr_nxt  = RRESP;
    if (ARVALID && ARREADY) begin
      rv_nxt  = 1'b1;
      rr_nxt  = `CLEQE_RESP_OKAY;
      rd_nxt  = '0;
      if (ARADDR == `CLEQE_OFS_CTRL) begin
        rd_nxt = {31'h0, en_r};
      end else if (ARADDR == `CLEQE_OFS_STATUS) begin
        rd_nxt = cycles_r;
      end else if (ARADDR == `CLEQE_OFS_OUTS) begin
        rd_nxt = {16'h0, lat_r, out_r};
      end else if (ARADDR >= `CLEQE_OFS_EQ_BASE && a < 12'(NEQ * 16)
                   && a[3:2] == `CLEQE_EQ_STAT) begin
        rd_nxt = {24'h0, st_r[e].lat, st_r[e].unl, st_r[e].gate_q,
                  st_r[e].rst, st_r[e].ins};
      end else if (ARADDR >= `CLEQE_OFS_EQ_BASE && a < 12'(NEQ * 16)
                   && a[3:2] == `CLEQE_EQ_SEL) begin
        for (int i = 0; i < 4; i++) begin
          rd_nxt[8*i +: `CLEQE_SEL_W] = cfg_r[e].equation_input_slot[i];
        end
      end else if (ARADDR >= `CLEQE_OFS_EQ_BASE && a < 12'(NEQ * 16)
                   && a[3:2] == `CLEQE_EQ_CFG) begin
        rd_nxt[`CLEQE_CFG_INV_LO +: 4]             = cfg_r[e].inv;
        rd_nxt[`CLEQE_CFG_RINV]                    = cfg_r[e].rst_inv;
        rd_nxt[`CLEQE_CFG_GATE_LO +: 2]            = cfg_r[e].gate;
        rd_nxt[`CLEQE_CFG_RSEL_LO +: `CLEQE_SEL_W] = cfg_r[e].rst_sel;
      end else if (ARADDR >= `CLEQE_OFS_EQ_BASE && a < 12'(NEQ * 16)
                   && a[3:2] == `CLEQE_EQ_DLY) begin
        rd_nxt = {cfg_r[e].equation_fall_delay, cfg_r[e].equation_rise_delay};
      end else begin
        rr_nxt = `CLEQE_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cfg_r   <= '0;
      en_r    <= `CLEQE_CTRL_RST;
      aw_h_r  <= 1'b0;
      w_h_r   <= 1'b0;
      awa_r   <= '0;
      wd_r    <= '0;
      ws_r    <= '0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `CLEQE_RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RRESP   <= `CLEQE_RESP_OKAY;
      RDATA   <= '0;
    end else begin
      cfg_r   <= cfg_nxt;
      en_r    <= en_nxt;
      aw_h_r  <= aw_h_nxt;
      w_h_r   <= w_h_nxt;
      awa_r   <= awa_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      AWREADY <= awr_nxt;
      WREADY  <= wr_nxt;
      BVALID  <= bv_nxt;
      BRESP   <= br_nxt;
      ARREADY <= arr_nxt;
      RVALID  <= rv_nxt;
      RRESP   <= rr_nxt;
      RDATA   <= rd_nxt;
    end
  end

endmodule : cleqe_engine
`default_nettype wire

// [rtl/cleqe_pkg.sv]
// Types shared by the logic equation engine.
// Assumes cleqe_cfg.svh is included first.
`include "cleqe_cfg.svh"
package cleqe_pkg;
  // ==========================================================================
  // Gate functions.
  typedef enum logic [1:0] {
    GATE_AND,
    GATE_OR,
    GATE_NAND,
    GATE_NOR
  } cleqe_gate_t;

  // Configuration of one equation.
  typedef struct packed {
    logic [3:0][`CLEQE_SEL_W-1:0] equation_input_slot;
    logic [3:0]                   inv;
    logic [`CLEQE_SEL_W-1:0]      rst_sel;
    logic                         rst_inv;
    cleqe_gate_t                  gate;
    logic [`CLEQE_DLY_W-1:0]      equation_rise_delay;
    logic [`CLEQE_DLY_W-1:0]      equation_fall_delay;
  } cleqe_eqcfg_t;

  // State of one equation.
  typedef struct packed {
    logic [3:0]              ins;
    logic                    rst;
    logic                    gate_q;
    logic                    unl;
    logic                    lat;
    logic [`CLEQE_DLY_W-1:0] cnt;
  } cleqe_eqst_t;

  // Sequencer states.
  typedef enum logic {
    SEQ_IDLE,
    SEQ_RUN
  } cleqe_seq_t;
endpackage : cleqe_pkg

// [tb/cleqe_engine_assertions.sv]
// Port checker for the logic equation engine.
// Assumes it is bound to cleqe_engine and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cleqe_engine_assertions (
  input wire logic       CLOCK,        // Clock.
  input wire logic       RESETN,       // Reset, active low.
  input wire logic [7:0] EQ_OUT,       // Unlatched results.
  input wire logic [7:0] EQ_LATCHED,   // Latched results.
  input wire logic [7:0] EQ_LATCHED_N, // Complemented latches.
  input wire logic       CYCLE_DONE,   // End of cycle pulse.
  input wire logic       AWVALID,      // Bus signals follow.
  input wire logic       AWREADY,      // Address ready.
  input wire logic       WVALID,       // Data valid.
  input wire logic       WREADY,       // Data ready.
  input wire logic       BVALID,       // Response valid.
  input wire logic       BREADY,       // Response ready.
  input wire logic       ARVALID,      // Read address valid.
  input wire logic       ARREADY,      // Read address ready.
  input wire logic       RVALID,       // Read data valid.
  input wire logic       RREADY        // Read data ready.
);
  // ==========================================================================
  // Equation outputs.
  // One equation per clock, so at most one bit of each vector moves per edge.
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  a_latch_compl: assert property (EQ_LATCHED_N == ~EQ_LATCHED)
    else $error("latched complement wrong");
  a_out_slot: assert property ($countones(EQ_OUT ^ $past(EQ_OUT)) <= 1)
    else $error("two results moved at once");
  a_lat_slot: assert property ($countones(EQ_LATCHED ^ $past(EQ_LATCHED)) <= 1)
    else $error("two latches moved at once");
  a_latch_cause: assert property (((EQ_LATCHED & ~$past(EQ_LATCHED))
    & ~EQ_OUT & ~$past(EQ_OUT)) == 8'h00)
    else $error("latch set without result");
  a_done_gap: assert property (CYCLE_DONE |=> !CYCLE_DONE [*7])
    else $error("cycle shorter than eight clocks");
  // ==========================================================================
  // Register bus.
  a_write_resp: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("write response late");
  a_read_resp: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  a_b_once: assert property (BVALID && BREADY |=> !BVALID)
    else $error("response repeated");
  a_r_once: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data repeated");
  a_ar_block: assert property (RVALID |-> !ARREADY)
    else $error("read taken while busy");
  a_w_block: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while busy");
  c_done: cover property (CYCLE_DONE);
  c_latch: cover property ($rose(EQ_LATCHED[1]));
  c_write: cover property (BVALID && BREADY);
  c_read: cover property (RVALID && RREADY);
endmodule : cleqe_engine_assertions
`default_nettype wire

// [tb/cleqe_field.sv]
// Far-side model: the field signals that feed the equation engine.
// Assumes the bench supplies the wanted levels and the clock.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Field signal source.
module cleqe_field (
  input  wire logic        clk,  // Bench clock.
  input  wire logic        slow, // Adds one clock of lag.
  input  wire logic [31:0] want, // Levels the field should show.
  output var  logic [31:0] sigs  // Assignable signals to the engine.
);
  logic [31:0] lag_r;
  // Known levels from time zero, so the engine never samples an unknown.
  initial begin
    lag_r = 32'h0;
    sigs  = 32'h0;
  end
  // Contacts move just after an edge; slow mode mimics a sluggish input card.
  always @(posedge clk) begin
    lag_r <= want;
    sigs  <= slow ? lag_r : want;
  end
endmodule : cleqe_field
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the logic equation engine.
// Assumes cleqe_cfg.svh, the package and the engine are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cleqe_cfg.svh"
module tb_top;
  typedef struct packed {
    cleqe_pkg::cleqe_gate_t g;
    logic [3:0]             inv;
    logic [3:0]             sig;
    logic                   e;
  } cleqe_row_t;
  logic        CLOCK = 1'b0, RESETN = 1'b0, slow = 1'b0;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, CYCLE_DONE;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0, want = 32'h0, RDATA, SIGNALS_IN, rdat, prev;
  logic [7:0]  EQ_OUT, EQ_LATCHED, EQ_LATCHED_N;
  logic [3:0]  WSTRB = 4'hF;
  logic [1:0]  BRESP, RRESP, resp;
  int          mismatches = 0, comparisons = 0, n;
  cleqe_row_t  rows [10] = '{
    '{cleqe_pkg::GATE_AND, 4'h0, 4'hF, 1'b1}, '{cleqe_pkg::GATE_AND, 4'h0, 4'h7, 1'b0},
    '{cleqe_pkg::GATE_OR, 4'h0, 4'h0, 1'b0}, '{cleqe_pkg::GATE_OR, 4'h0, 4'h8, 1'b1},
    '{cleqe_pkg::GATE_NAND, 4'h0, 4'hF, 1'b0}, '{cleqe_pkg::GATE_NAND, 4'h0, 4'hE, 1'b1},
    '{cleqe_pkg::GATE_NOR, 4'h0, 4'h0, 1'b1}, '{cleqe_pkg::GATE_NOR, 4'h0, 4'h2, 1'b0},
    '{cleqe_pkg::GATE_AND, 4'hF, 4'h0, 1'b1}, '{cleqe_pkg::GATE_OR, 4'h5, 4'h5, 1'b0}};
  // ==========================================================================
  // Clock, design and field model.
  always #5 CLOCK = ~CLOCK;
  cleqe_engine dut (.CLOCK(CLOCK), .RESETN(RESETN), .SIGNALS_IN(SIGNALS_IN),
    .EQ_OUT(EQ_OUT), .EQ_LATCHED(EQ_LATCHED), .EQ_LATCHED_N(EQ_LATCHED_N),
    .CYCLE_DONE(CYCLE_DONE), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  cleqe_field fld (.clk(CLOCK), .slow(slow), .want(want), .sigs(SIGNALS_IN));
  // ==========================================================================
  // Helpers. Readies are sampled at the falling edge, where they are settled.
  function automatic logic [11:0] ea(input int q, input int r);
    return `CLEQE_OFS_EQ_BASE + 12'(q * 16 + r * 4);
  endfunction : ea
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic wt(input int k);
    repeat (k) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask : wt
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, ra, rw;
    ha = 1'b0;
    hw = 1'b0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(ha && hw)) begin
      @(negedge CLOCK);
      ra = AWREADY && !ha;
      rw = WREADY && !hw;
      @(posedge CLOCK);
      if (ra) AWVALID <= 1'b0;
      if (rw) WVALID <= 1'b0;
      ha = ha | ra;
      hw = hw | rw;
    end
    ra = 1'b0;
    while (!ra) begin
      @(negedge CLOCK);
      ra = BVALID;
      resp = BRESP;
      @(posedge CLOCK);
    end
    BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic h;
    h = 1'b0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!h) begin
      @(negedge CLOCK);
      h = ARREADY;
      @(posedge CLOCK);
    end
    ARVALID <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge CLOCK);
      h = RVALID;
      rdat = RDATA;
      resp = RRESP;
      @(posedge CLOCK);
    end
    RREADY <= 1'b0;
  endtask : rd
  // Clocks from a rise of result p to the rise of result q.
  task automatic gap(input int p, input int q, output int k);
    k = 0;
    while (EQ_OUT[p] !== 1'b1) @(negedge CLOCK);
    while (EQ_OUT[q] !== 1'b1) begin
      @(negedge CLOCK);
      k++;
    end
  endtask : gap
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Watchdog; the whole sequence needs about a thousand clocks.
  initial begin
    repeat (20000) @(posedge CLOCK);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    @(negedge CLOCK);
    chk(EQ_LATCHED_N === 8'hFF && EQ_OUT === 8'h00, "reset outputs");
    repeat (3) @(posedge CLOCK);
    RESETN <= 1'b1;
    rd(`CLEQE_OFS_CTRL);
    chk(rdat === 32'h0, "control reset value");
    wr(`CLEQE_OFS_CTRL, 32'h1);
    chk(resp === `CLEQE_RESP_OKAY, "write okay");
    wr(ea(0, 0), 32'h03020100);
    // Each gate with plain inputs, AND and OR also with inverted ones, all delays zero.
    foreach (rows[i]) begin
      wr(ea(0, 1), {22'h0, rows[i].g, 4'h0, rows[i].inv});
      want <= {28'h0, rows[i].sig};
      wt(30);
      chk(EQ_OUT[0] === rows[i].e, "gate row");
    end
    // Rise delay 3 and fall delay 2 cycles, with a sluggish field.
    wr(ea(0, 1), 32'h0);
    wr(ea(0, 2), 32'h00020003);
    want <= 32'h0;
    slow <= 1'b1;
    wt(30);
    want <= 32'hF;
    wt(11);
    chk(EQ_OUT[0] === 1'b0, "rise too early");
    wt(40);
    chk(EQ_OUT[0] === 1'b1, "rise missing");
    want <= 32'h0;
    wt(11);
    chk(EQ_OUT[0] === 1'b1, "fall too early");
    wt(40);
    chk(EQ_OUT[0] === 1'b0, "fall missing");
    wr(ea(0, 2), 32'h0);
    slow <= 1'b0;
    // Latch on equation 1: set from signal 4, reset from signal 5.
    wr(ea(1, 0), 32'h04040404);
    wr(ea(1, 1), 32'h00050100);
    want <= 32'h10;
    wt(30);
    chk(EQ_LATCHED[1] === 1'b1 && EQ_LATCHED_N[1] === 1'b0, "latch set");
    want <= 32'h0;
    wt(30);
    chk(EQ_OUT[1] === 1'b0 && EQ_LATCHED[1] === 1'b1, "latch hold");
    want <= 32'h30;
    wt(30);
    chk(EQ_OUT[1] === 1'b1 && EQ_LATCHED[1] === 1'b0, "reset dominance");
    wr(ea(1, 1), 32'h00050110);
    want <= 32'h10;
    wt(30);
    chk(EQ_LATCHED[1] === 1'b0, "inverted reset active");
    want <= 32'h30;
    wt(30);
    chk(EQ_LATCHED[1] === 1'b1, "inverted reset idle");
    // Cascades: 0 feeds 2 in the same cycle, 3 feeds 1 a cycle later.
    wr(ea(1, 1), 32'h0);
    wr(ea(1, 0), 32'h23232323);
    wr(ea(2, 0), 32'h20202020);
    wr(ea(3, 0), 32'h06060606);
    want <= 32'h0;
    wt(30);
    want <= 32'hF;
    gap(0, 2, n);
    chk(n == 2, "ascending cascade age");
    want <= 32'h4F;
    gap(3, 1, n);
    chk(n == 6, "descending cascade age");
    // Status readback and bus refusals.
    wt(20);
    rd(ea(0, 3));
    chk(rdat[7:0] === 8'h7F, "equation status");
    rd(`CLEQE_OFS_OUTS);
    chk(rdat[15:0] === 16'h00FF, "output states");
    rd(`CLEQE_OFS_STATUS);
    prev = rdat;
    wt(16);
    rd(`CLEQE_OFS_STATUS);
    chk(rdat - prev >= 32'h2, "cycles repeat");
    rd(12'h0F0);
    chk(resp === `CLEQE_RESP_SLVERR && rdat === 32'h0, "unmapped read");
    wr(12'h0F0, 32'hFFFFFFFF);
    chk(resp === `CLEQE_RESP_SLVERR, "unmapped write");
    // One strobed byte must leave the other selector slots untouched.
    WSTRB <= 4'h2;
    wr(ea(2, 0), 32'h00001500);
    WSTRB <= 4'hF;
    rd(ea(2, 0));
    chk(rdat === 32'h20201520, "strobed selector write");
    final_report();
  end
endmodule : tb_top
bind cleqe_engine cleqe_engine_assertions chk_i (.CLOCK(CLOCK), .RESETN(RESETN),
  .EQ_OUT(EQ_OUT), .EQ_LATCHED(EQ_LATCHED), .EQ_LATCHED_N(EQ_LATCHED_N),
  .CYCLE_DONE(CYCLE_DONE), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY));
`default_nettype wire
